//--- rtl/dpc_map.vh
// register map, field positions and fetch constants for the dma
// priority and chain loader; included by the arbiter, not by the rotating pick
`ifndef DPC_MAP_VH
`define DPC_MAP_VH
// register index inside a channel window (byte address ch*16 + idx*4)
`define DPC_REG_CTRL 2'h0
`define DPC_REG_COUNT 2'h1
`define DPC_REG_CHAIN 2'h2
// global registers, byte addresses
`define DPC_CHAN_LIMIT 8'hA0
`define DPC_SYSCFG_ADDR 8'hA0
`define DPC_STATUS_ADDR 8'hA4
`define DPC_LINKCTL_ADDR 8'hA8
// channel control bits
`define DPC_CTRL_EN 0
`define DPC_CTRL_CHAIN_ENABLE 1
`define DPC_CTRL_TWOD 2
`define DPC_CTRL_LTX 3
`define DPC_CTRL_W 4
// reset values
`define DPC_CTRL_RST 4'h0
`define DPC_CP_RST 18'h00000
`define DPC_COUNT_RST 16'h0000
// chain pointer layout
`define DPC_CP_PCI 17
`define DPC_MEM_OFFSET 18'h20000
// control block word indices, word k sits at pointer minus k
`define DPC_IDX_COUNT 4'h2
`define DPC_IDX_CHAIN 4'h3
`define DPC_IDX_GP 4'h4
`define DPC_IDX_STRIDE 4'h5
`define DPC_IDX_MESH1 4'h6
`define DPC_IDX_EXT_LAST 4'h7
`define DPC_IDX_MESH_LAST 4'h8
`endif

//--- rtl/dpc_rot_pick.v
// rotating priority pick among the four external-port channels
// assumes base names the group member that currently ranks highest
module dpc_rot_pick (
	input wire [3:0] req, // requests, bit 0 is channel 6
	input wire [1:0] base, // group member with highest rank
	output reg valid, // some request present
	output reg [1:0] idx // winning member
);
	integer k;
	reg [1:0] cand;

	// walk from base upward, wrapping from the last back to the first
	always @*
	begin
		valid = 1'b0;
		idx = 2'h0;
		cand = 2'h0;
		for (k = 3; k >= 0; k = k - 1)
		begin
			cand = base + k[1:0];
			if (req[cand])
			begin
				valid = 1'b1;
				idx = cand;
			end
		end
	end
endmodule // dpc_rot_pick

//--- rtl/dpc_dma_arbiter.v
// i/o bus arbiter and control block chain loader for ten dma channels
// assumes requests come from logic on core_clk, memory answers a read
// one cycle after mem_rd_en, and registers sit on classic wishbone
// Function
// - priority is recomputed every clock, between any two single words
// - external bus release pulses only when an external block completes
// - direct accesses and block fetches share the channel priority scheme
// - block fetch words outrank direct external accesses of memory
// - one config bit picks rotating or fixed order for channels 6-9
// - rotation makes the served channel lowest, the next one highest
// - reset clears the rotation enable, fixed order at start
// - fixed order after reset is 6, 7, 8, 9
// - rotation reorders only inside the external group
// - turning rotation off keeps the last rotated order
// - interrupt requests stay per channel, unaffected by rotation
// - exhausted chained channel fetches its next control block
// - chaining needs the chain enable bit and a nonzero pointer
// - pointer write with the channel and chaining enabled starts a fetch, any time
// - pointer is 18 bits, 17 address bits offset, bit 17 irq enable
// - chained channels raise done only with pointer irq bit set
// - words fetched downward from pointer in the fixed register order
// - external channels always fetch all eight words
// - 2d mode on channels 0-5 fetches the stride and copies count to 2d count
// - mesh path words fetched only for link transmit with mesh on
// - hidden pointer counts down per word, then takes new pointer
// - fetch request latched until won, highest ranked channel fetched first
// - a channel loading its block is never pre-empted by another fetch
// - a disabled channel is never granted
// - transfer starts the cycle after the grant
// - next sequence starts only if the pointer address is nonzero
`include "dpc_map.vh"
module dpc_dma_arbiter #(
	parameter NCH = 10 // channel count, fixed layout below
) (
	input wire core_clk, // core clock
	input wire rst_n, // async reset, low active
	input wire wb_cyc_i, // wishbone cycle
	input wire wb_stb_i, // wishbone strobe
	input wire wb_we_i, // wishbone write
	input wire [7:0] wb_adr_i, // byte address
	input wire [31:0] wb_dat_i, // write data
	input wire [3:0] wb_sel_i, // byte enables
	output reg [31:0] wb_dat_o, // read data
	output reg wb_ack_o, // acknowledge
	input wire [9:0] dma_req, // channel word requests
	output reg [9:0] dma_grant, // channel grants
	input wire direct_req, // external direct access of memory
	output reg direct_grant, // grant for the direct access
	output reg mem_rd_en, // control block word read
	output reg [17:0] mem_rd_addr, // offset word address
	input wire [31:0] mem_rdata, // word, valid cycle after mem_rd_en
	output reg load_valid, // parameter register load strobe
	output reg [3:0] load_chan, // channel being loaded
	output reg [3:0] load_sel, // word index in the block
	output reg load_twod_copy, // also load 2d count from this word
	output reg [31:0] load_data, // word to load
	output reg [9:0] chan_done, // sequence end interrupt requests
	output reg ext_bus_release // external block done, bus may go
);
	reg [`DPC_CTRL_W-1:0] ctrl [0:9];
	reg [15:0] cnt [0:9];
	reg [17:0] cp [0:9];
	reg [9:0] seq_active;
	reg [9:0] fetch_pend;
	reg rotate_ext_priority_enable;
	reg mesh_link_enable;
	reg [1:0] rot_base;
	reg fetch_busy;
	reg fetch_issued;
	reg [3:0] fetch_chan;
	reg [3:0] fetch_idx;
	reg [16:0] wp;
	reg rd_v;
	reg [3:0] rd_chan;
	reg [3:0] rd_idx;
	reg [9:0] data_ok;
	reg fetch_gnt;
	reg [3:0] pick_chan;
	reg pick_any;
	wire ext_v;
	wire [1:0] ext_idx;
	wire pend_ext_v;
	wire [1:0] pend_ext_idx;
	wire wb_req;
	wire [3:0] wb_ch;
	wire [1:0] wb_reg;
	wire wb_in_chan;
	wire [31:0] mrg_ctrl;
	wire [31:0] mrg_cnt;
	wire [31:0] mrg_cp;
	integer i;

	// byte lane merge for register writes
	function [31:0] dpc_merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		integer b;
		begin
			dpc_merge = old;
			for (b = 0; b < 4; b = b + 1)
			begin
				if (sel[b])
					dpc_merge[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
	endfunction

	// last word index of a block for this channel and mode
	function [3:0] dpc_last;
		input [3:0] ch;
		input [`DPC_CTRL_W-1:0] c;
		input mesh;
		begin
			if (ch >= 4'h6)
				dpc_last = `DPC_IDX_EXT_LAST;
			else if (c[`DPC_CTRL_LTX] && mesh)
				dpc_last = `DPC_IDX_MESH_LAST;
			else if (c[`DPC_CTRL_TWOD])
				dpc_last = `DPC_IDX_STRIDE;
			else
				dpc_last = `DPC_IDX_GP;
		end
	endfunction

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_ch = wb_adr_i[7:4];
	assign wb_reg = wb_adr_i[3:2];
	assign wb_in_chan = (wb_adr_i < `DPC_CHAN_LIMIT);

	// merged write words, cut back to register width where stored
	assign mrg_ctrl = dpc_merge({28'h0, ctrl[wb_ch]}, wb_dat_i, wb_sel_i);
	assign mrg_cnt = dpc_merge({16'h0, cnt[wb_ch]}, wb_dat_i, wb_sel_i);
	assign mrg_cp = dpc_merge({14'h0, cp[wb_ch]}, wb_dat_i, wb_sel_i);

	// group picks: one for data words, one for pending fetches
	dpc_rot_pick u_pick_data (
		.req(data_ok[9:6]),
		.base(rot_base),
		.valid(ext_v),
		.idx(ext_idx)
	);
	dpc_rot_pick u_pick_fetch (
		.req(fetch_pend[9:6]),
		.base(rot_base),
		.valid(pend_ext_v),
		.idx(pend_ext_idx)
	);

	// channels that may move a word this cycle
	always @*
	begin
		for (i = 0; i < NCH; i = i + 1)
			data_ok[i] = dma_req[i] & ctrl[i][`DPC_CTRL_EN]
				& seq_active[i];
	end

	// bus grant, fixed ranks around the rotating external group
	always @*
	begin
		dma_grant = 10'h000;
		fetch_gnt = 1'b0;
		direct_grant = 1'b0;
		if (data_ok[0])
			dma_grant[0] = 1'b1;
		else if (data_ok[1])
			dma_grant[1] = 1'b1;
		else if (data_ok[2])
			dma_grant[2] = 1'b1;
		else if (data_ok[3])
			dma_grant[3] = 1'b1;
		else if (fetch_busy && !fetch_issued)
			fetch_gnt = 1'b1;
		else if (direct_req)
			direct_grant = 1'b1;
		else if (data_ok[4])
			dma_grant[4] = 1'b1;
		else if (data_ok[5])
			dma_grant[5] = 1'b1;
		else if (ext_v)
			dma_grant[6 + ext_idx] = 1'b1;
	end

	// highest ranked channel among latched fetch requests
	always @*
	begin
		pick_any = 1'b1;
		pick_chan = 4'h0;
		if (fetch_pend[0])
			pick_chan = 4'h0;
		else if (fetch_pend[1])
			pick_chan = 4'h1;
		else if (fetch_pend[2])
			pick_chan = 4'h2;
		else if (fetch_pend[3])
			pick_chan = 4'h3;
		else if (fetch_pend[4])
			pick_chan = 4'h4;
		else if (fetch_pend[5])
			pick_chan = 4'h5;
		else if (pend_ext_v)
			pick_chan = 4'h6 + {2'h0, pend_ext_idx};
		else
			pick_any = 1'b0;
	end

	// memory read for the fetch word; data is back a cycle later
	always @*
	begin
		mem_rd_en = fetch_gnt;
		mem_rd_addr = {1'b0, wp} + `DPC_MEM_OFFSET;
	end

	// rotation state and global configuration
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rotate_ext_priority_enable <= 1'b0;
			mesh_link_enable <= 1'b0;
			rot_base <= 2'h0;
		end
		else
		begin
			if (wb_req && wb_we_i && wb_adr_i == `DPC_SYSCFG_ADDR
				&& wb_sel_i[0])
				rotate_ext_priority_enable <= wb_dat_i[0];
			if (wb_req && wb_we_i && wb_adr_i == `DPC_LINKCTL_ADDR
				&& wb_sel_i[0])
				mesh_link_enable <= wb_dat_i[0];
			// only a real word on the group moves the base; held when off
			if (rotate_ext_priority_enable && ext_v
				&& dma_grant[6 + ext_idx])
				rot_base <= ext_idx + 2'h1;
		end
	end

	// fetch sequencer with hidden working pointer
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fetch_busy <= 1'b0;
			fetch_issued <= 1'b0;
			fetch_chan <= 4'h0;
			fetch_idx <= 4'h0;
			wp <= 17'h00000;
			rd_v <= 1'b0;
			rd_chan <= 4'h0;
			rd_idx <= 4'h0;
		end
		else
		begin
			rd_v <= fetch_gnt;
			rd_chan <= fetch_chan;
			rd_idx <= fetch_idx;
			if (!fetch_busy && pick_any)
			begin
				// locked on this channel until its last word returns
				fetch_busy <= 1'b1;
				fetch_issued <= 1'b0;
				fetch_chan <= pick_chan;
				fetch_idx <= 4'h0;
				wp <= cp[pick_chan][16:0];
			end
			else if (fetch_gnt)
			begin
				if (fetch_idx == dpc_last(fetch_chan, ctrl[fetch_chan],
					mesh_link_enable))
					fetch_issued <= 1'b1;
				else if (fetch_chan < 4'h6 && fetch_idx == `DPC_IDX_GP
					&& !ctrl[fetch_chan][`DPC_CTRL_TWOD])
				begin
					// 1d link tx with mesh: stride slot skipped
					fetch_idx <= `DPC_IDX_MESH1;
					wp <= wp - 17'h00002;
				end
				else
				begin
					fetch_idx <= fetch_idx + 4'h1;
					wp <= wp - 17'h00001;
				end
			end
			if (rd_v && rd_idx == dpc_last(rd_chan, ctrl[rd_chan],
				mesh_link_enable))
			begin
				fetch_busy <= 1'b0;
				// looped chains reuse the freshly loaded pointer
				wp <= cp[rd_chan][16:0];
			end
		end
	end

	// parameter load port, registered from the returned word
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			load_valid <= 1'b0;
			load_chan <= 4'h0;
			load_sel <= 4'h0;
			load_twod_copy <= 1'b0;
			load_data <= 32'h00000000;
		end
		else
		begin
			load_valid <= rd_v;
			load_chan <= rd_chan;
			load_sel <= rd_idx;
			load_twod_copy <= rd_v && rd_idx == `DPC_IDX_COUNT
				&& rd_chan < 4'h6 && ctrl[rd_chan][`DPC_CTRL_TWOD];
			load_data <= mem_rdata;
		end
	end

	// channel state: control, count, pointer, sequence and fetch flags
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (i = 0; i < NCH; i = i + 1)
			begin
				ctrl[i] <= `DPC_CTRL_RST;
				cnt[i] <= `DPC_COUNT_RST;
				cp[i] <= `DPC_CP_RST;
			end
			seq_active <= 10'h000;
			fetch_pend <= 10'h000;
			chan_done <= 10'h000;
			ext_bus_release <= 1'b0;
		end
		else
		begin
			chan_done <= 10'h000;
			ext_bus_release <= 1'b0;
			if (!fetch_busy && pick_any)
				fetch_pend[pick_chan] <= 1'b0;
			// software writes; hardware updates below win on collision
			if (wb_req && wb_we_i && wb_in_chan && wb_ch < 4'hA)
			begin
				if (wb_reg == `DPC_REG_CTRL)
				begin
					ctrl[wb_ch] <= mrg_ctrl[`DPC_CTRL_W-1:0];
					// unchained start on enable rising
					if (wb_sel_i[0] && wb_dat_i[`DPC_CTRL_EN]
						&& !wb_dat_i[`DPC_CTRL_CHAIN_ENABLE]
						&& !ctrl[wb_ch][`DPC_CTRL_EN])
						seq_active[wb_ch] <= 1'b1;
				end
				else if (wb_reg == `DPC_REG_COUNT)
					cnt[wb_ch] <= mrg_cnt[15:0];
				else if (wb_reg == `DPC_REG_CHAIN)
				begin
					cp[wb_ch] <= mrg_cp[17:0];
					if (ctrl[wb_ch][`DPC_CTRL_EN]
						&& ctrl[wb_ch][`DPC_CTRL_CHAIN_ENABLE]
						&& wb_dat_i[16:0] != 17'h00000)
					begin
						fetch_pend[wb_ch] <= 1'b1;
						seq_active[wb_ch] <= 1'b0;
					end
				end
			end
			// returned block words that this block keeps itself
			if (rd_v && rd_idx == `DPC_IDX_COUNT)
				cnt[rd_chan] <= mem_rdata[15:0];
			if (rd_v && rd_idx == `DPC_IDX_CHAIN)
				cp[rd_chan] <= mem_rdata[17:0];
			if (rd_v && rd_idx == dpc_last(rd_chan, ctrl[rd_chan],
				mesh_link_enable))
				seq_active[rd_chan] <= 1'b1;
			// word transfers, the port moves it next cycle
			for (i = 0; i < NCH; i = i + 1)
			begin
				if (dma_grant[i])
				begin
					cnt[i] <= cnt[i] - 16'h0001;
					if (cnt[i] == 16'h0001)
					begin
						seq_active[i] <= 1'b0;
						if (i >= 6)
							ext_bus_release <= 1'b1;
						if (ctrl[i][`DPC_CTRL_CHAIN_ENABLE])
						begin
							chan_done[i] <= cp[i][`DPC_CP_PCI];
							if (cp[i][16:0] != 17'h00000)
								fetch_pend[i] <= 1'b1;
						end
						else
							chan_done[i] <= 1'b1;
					end
				end
			end
		end
	end

	// wishbone answer, one cycle after the request, unmapped reads zero
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h00000000;
			if (wb_req && !wb_we_i)
			begin
				if (wb_in_chan && wb_ch < 4'hA)
				begin
					if (wb_reg == `DPC_REG_CTRL)
						wb_dat_o <= {22'h0, fetch_pend[wb_ch],
							seq_active[wb_ch], 4'h0, ctrl[wb_ch]};
					else if (wb_reg == `DPC_REG_COUNT)
						wb_dat_o <= {16'h0, cnt[wb_ch]};
					else if (wb_reg == `DPC_REG_CHAIN)
						wb_dat_o <= {14'h0, cp[wb_ch]};
				end
				else if (wb_adr_i == `DPC_SYSCFG_ADDR)
					wb_dat_o <= {31'h0, rotate_ext_priority_enable};
				else if (wb_adr_i == `DPC_STATUS_ADDR)
					wb_dat_o <= {11'h000, fetch_busy, fetch_chan, 4'h0,
						rot_base, fetch_pend};
				else if (wb_adr_i == `DPC_LINKCTL_ADDR)
					wb_dat_o <= {31'h0, mesh_link_enable};
			end
		end
	end
endmodule // dpc_dma_arbiter

//--- tb/dpc_dma_arbiter_props.sv
// port level assertions for the dma arbiter and chain loader
// assumes one core clock domain with an async active low reset
module dpc_dma_arbiter_props (
	input wire core_clk, // core clock
	input wire rst_n, // async reset, low active
	input wire wb_cyc_i, // wishbone cycle
	input wire wb_stb_i, // wishbone strobe
	input wire wb_ack_o, // acknowledge
	input wire [9:0] dma_req, // channel requests
	input wire [9:0] dma_grant, // channel grants
	input wire direct_req, // direct access request
	input wire direct_grant, // direct access grant
	input wire mem_rd_en, // block word read
	input wire [17:0] mem_rd_addr, // word address
	input wire load_valid, // load strobe
	input wire [3:0] load_chan, // channel loaded
	input wire [3:0] load_sel, // word index
	input wire [9:0] chan_done, // sequence end
	input wire ext_bus_release // external block done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// one owner of the i/o bus per cycle, fetch words included
	bus_owner_a: assert property ($onehot0({dma_grant, direct_grant, mem_rd_en}))
		else $error("two owners of the i/o bus");
	idle_skip_a: assert property ((dma_grant & ~dma_req) == 10'h000)
		else $error("grant without request");
	direct_rank_a: assert property (direct_req |-> dma_grant[9:4] == 6'h00)
		else $error("low channel beat a direct access");
	load_lag_a: assert property (mem_rd_en |-> ##2 load_valid)
		else $error("fetched word not loaded two cycles on");
	rd_offset_a: assert property (mem_rd_en |-> mem_rd_addr[17])
		else $error("fetch address lacks memory offset");
	// consecutive loads belong to one block and climb in index
	load_order_a: assert property (load_valid && $past(load_valid) |->
		load_chan == $past(load_chan) && load_sel > $past(load_sel))
		else $error("block load order broken");
	done_cause_a: assert property ((chan_done & ~$past(dma_grant)) == 10'h000)
		else $error("sequence end without a granted word");
	release_cause_a: assert property (ext_bus_release |->
		$past(dma_grant[9:6]) != 4'h0)
		else $error("bus release without external word");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not in the next cycle");
endmodule // dpc_dma_arbiter_props

bind dpc_dma_arbiter dpc_dma_arbiter_props u_props (.core_clk, .rst_n,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .dma_req, .dma_grant, .direct_req,
	.direct_grant, .mem_rd_en, .mem_rd_addr, .load_valid, .load_chan,
	.load_sel, .chan_done, .ext_bus_release);

//--- tb/dpc_mem_model.sv
// internal memory model that answers control block reads
// assumes one read per cycle, data wanted the cycle after
module dpc_mem_model (
	input wire core_clk, // core clock
	input wire mem_rd_en, // read strobe
	input wire [17:0] mem_rd_addr, // word address, offset included
	output logic [31:0] mem_rdata // word, one cycle after the read
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:31]; // small store, filled by the bench
	initial mem_rdata = 32'h0;
	// word holds one cycle only; inverted after so stale use shows
	always @(posedge core_clk)
		mem_rdata <= mem_rd_en ? mem[mem_rd_addr[4:0]] : ~mem_rdata;
endmodule // dpc_mem_model

//--- tb/test_dpc_dma_arbiter.sv
// self checking bench for the dma arbiter and chain loader
// assumes the arbiter, checker and memory model are compiled first
module test_dpc_dma_arbiter;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [9:0] req; logic dir;
		logic [9:0] g; logic dg;} dpc_row_t;
	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic wb_cyc_i = 1'h0;
	logic wb_stb_i = 1'h0;
	logic wb_we_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [9:0] dma_req = 10'h000;
	logic direct_req = 1'h0;
	wire [31:0] wb_dat_o, mem_rdata, load_data;
	wire wb_ack_o, direct_grant, mem_rd_en, load_valid;
	wire load_twod_copy, ext_bus_release;
	wire [9:0] dma_grant, chan_done;
	wire [17:0] mem_rd_addr;
	wire [3:0] load_chan, load_sel;
	int error_cnt = 0;
	int checks_done = 0;
	int rel_cnt = 0;
	int done6 = 0;
	logic [17:0] rdq[$];
	logic [40:0] ldq[$];
	logic [31:0] rd;
	logic [3:0] s;
	dpc_row_t rows [9];
	dpc_dma_arbiter dut (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .dma_req,
		.dma_grant, .direct_req, .direct_grant, .mem_rd_en, .mem_rd_addr,
		.mem_rdata, .load_valid, .load_chan, .load_sel, .load_twod_copy,
		.load_data, .chan_done, .ext_bus_release);
	dpc_mem_model mm (.core_clk, .mem_rd_en, .mem_rd_addr, .mem_rdata);
	always #4 core_clk = ~core_clk;
	// log fetch traffic and sequence ends for later comparison
	always @(posedge core_clk)
	begin
		if (mem_rd_en) rdq.push_back(mem_rd_addr);
		if (load_valid)
			ldq.push_back({load_twod_copy, load_chan, load_sel,
				load_data});
		if (chan_done[6]) done6++;
		if (ext_bus_release) rel_cnt++;
	end
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t ns: got %h want %h", $time, seen, exp);
		end
	endtask
	// classic single cycle; waits for ack, bench watchdog ends a hang
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
			@(posedge core_clk);
		while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i <= 1'h0;
	endtask
	// grants are combinational: drive at the edge, look mid cycle
	task arb(input logic [9:0] r, input logic d, input logic [9:0] g,
		input logic dg);
		@(posedge core_clk);
		dma_req <= r;
		direct_req <= d;
		@(negedge core_clk);
		chk(32'({dma_grant, direct_grant}), 32'({g, dg}));
	endtask
	task wait_ld(input int k);
		int n;
		n = 0;
		while (ldq.size() < k && n < 100)
		begin
			@(posedge core_clk);
			n++;
		end
		chk(32'(ldq.size()), 32'(k));
	endtask
	// checks one block of n words fetched downward from ptr, t is 2d mode
	task chk_blk(input int b, input logic [17:0] p, input logic [3:0] c,
		input int n, input logic t);
		for (int i = 0; i < n; i++)
		begin
			s = (c == 4'h3 && i > 4) ? 4'(i + 1) : 4'(i);
			chk(32'(rdq[b + i]), 32'(p - 18'(s)));
			chk(32'(ldq[b + i][39:32]), 32'({c, s}));
			chk(32'(ldq[b + i][40]), 32'(t && s == 4'h2));
			chk(ldq[b + i][31:0], mm.mem[5'(p - 18'(s))]);
		end
	endtask
	// span well beyond the few hundred cycles the sequence needs
	initial
	begin
		#200000;
		error_cnt++;
		$display("unexpected at %0t ns: watchdog expired", $time);
		end_sim();
	end
	// main sequence: reset, fixed order table, then awkward cases
	initial
	begin
		rows = '{'{10'h3FF, 1'h0, 10'h001, 1'h0},
			'{10'h3FE, 1'h1, 10'h002, 1'h0}, '{10'h3F0, 1'h1, 10'h000, 1'h1},
			'{10'h3F0, 1'h0, 10'h010, 1'h0}, '{10'h3E0, 1'h0, 10'h020, 1'h0},
			'{10'h3C0, 1'h0, 10'h040, 1'h0}, '{10'h380, 1'h0, 10'h080, 1'h0},
			'{10'h300, 1'h0, 10'h100, 1'h0}, '{10'h200, 1'h0, 10'h200, 1'h0}};
		for (int i = 0; i < 32; i++)
			mm.mem[i] = 32'h100 | i;
		mm.mem[14] = 32'h1;
		mm.mem[13] = 32'h20008;
		mm.mem[6] = 32'h1;
		mm.mem[5] = 32'h0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'h1;
		wb(1'h0, 8'hA0, 32'h0);
		chk(rd, 32'h0);
		wb(1'h0, 8'h28, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 10; i++)
			wb(1'h1, 8'(i * 16), 32'h1);
		wb(1'h1, 8'h28, 32'hFFFFFFFF);
		wb(1'h0, 8'h28, 32'h0);
		chk(rd, 32'h0003FFFF);
		wb(1'h0, 8'hB0, 32'h0);
		chk(rd, 32'h0);
		chk(32'(rdq.size()), 32'h0);
		$display("test registers done");
		foreach (rows[i])
			arb(rows[i].req, rows[i].dir, rows[i].g, rows[i].dg);
		arb(10'h000, 1'h0, 10'h000, 1'h0);
		wb(1'h1, 8'h10, 32'h0);
		arb(10'h002, 1'h0, 10'h000, 1'h0);
		arb(10'h006, 1'h0, 10'h004, 1'h0);
		arb(10'h000, 1'h0, 10'h000, 1'h0);
		$display("test fixed order done");
		wb(1'h1, 8'hA0, 32'h1);
		arb(10'h3C0, 1'h0, 10'h040, 1'h0);
		arb(10'h080, 1'h0, 10'h080, 1'h0);
		arb(10'h3C0, 1'h0, 10'h100, 1'h0);
		arb(10'h3D0, 1'h0, 10'h010, 1'h0);
		arb(10'h240, 1'h0, 10'h200, 1'h0);
		arb(10'h280, 1'h0, 10'h080, 1'h0);
		arb(10'h000, 1'h0, 10'h000, 1'h0);
		wb(1'h1, 8'hA0, 32'h0);
		arb(10'h3C0, 1'h0, 10'h100, 1'h0);
		arb(10'h3C0, 1'h0, 10'h100, 1'h0);
		arb(10'h000, 1'h0, 10'h000, 1'h0);
		$display("test rotation done");
		rdq.delete();
		ldq.delete();
		rel_cnt = 0;
		done6 = 0;
		wb(1'h1, 8'h60, 32'h0);
		wb(1'h1, 8'h60, 32'h3);
		wb(1'h1, 8'h68, 32'h10);
		wait_ld(8);
		chk_blk(0, 18'h20010, 4'h6, 8, 1'h0);
		repeat (2) @(posedge core_clk);
		arb(10'h040, 1'h0, 10'h040, 1'h0);
		arb(10'h000, 1'h0, 10'h000, 1'h0);
		wait_ld(16);
		chk_blk(8, 18'h20008, 4'h6, 8, 1'h0);
		repeat (2) @(posedge core_clk);
		arb(10'h040, 1'h0, 10'h040, 1'h0);
		arb(10'h000, 1'h0, 10'h000, 1'h0);
		repeat (6) @(posedge core_clk);
		chk(32'(done6), 32'h1);
		chk(32'(rel_cnt), 32'h2);
		chk(32'(rdq.size()), 32'h10);
		$display("test chaining done");
		wb(1'h1, 8'hA8, 32'h1);
		wb(1'h1, 8'h30, 32'h0);
		wb(1'h1, 8'h30, 32'hB);
		wb(1'h1, 8'h38, 32'h1F);
		// serial channel 0 holds the bus, the fetch must wait latched
		repeat (5) arb(10'h001, 1'h1, 10'h001, 1'h0);
		// direct access keeps asking; the unfinished fetch must still win
		arb(10'h000, 1'h1, 10'h000, 1'h0);
		wait_ld(24);
		chk_blk(16, 18'h2001F, 4'h3, 8, 1'h0);
		chk(32'(rdq.size()), 32'h18);
		$display("test mesh fetch done");
		// 2d serial chain: stride fetched, count copied to 2d count
		wb(1'h1, 8'h20, 32'h7);
		wb(1'h1, 8'h28, 32'h1A);
		wait_ld(30);
		chk_blk(24, 18'h2001A, 4'h2, 6, 1'h1);
		chk(32'(rdq.size()), 32'h1E);
		$display("test twod fetch done");
		// reset in mid run must drop rotation and its base again
		wb(1'h1, 8'hA0, 32'h1);
		@(posedge core_clk);
		rst_n <= 1'h0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'h1;
		wb(1'h0, 8'hA0, 32'h0);
		chk(rd, 32'h0);
		wb(1'h0, 8'hA4, 32'h0);
		chk(rd, 32'h0);
		arb(10'h3C0, 1'h0, 10'h000, 1'h0);
		$display("test reset done");
		end_sim();
	end
endmodule // test_dpc_dma_arbiter
